// ===== tmcc_top.sv
// Function
// - each register has a 4-bit mode field; B high nibble, A low; zero disables
// - codes 0001-0011 start pin at 0, then match drives low, high or toggles
// - codes 0101-0111 start pin at 1, same match actions; 0100 stays disabled
// - code 1000 captures counter on rising edge of own pin
// - code 1001 captures on falling edge; 101x on both edges
// - code 11xx captures on channel 0 register C (for B) or A event
// - enable bit 7 allows converter start requests; resets to 0
// - enable bit 5 lets underflow flag raise underflow request; resets 0
// - enable bit 4 lets overflow flag raise overflow request; resets 0
// - enable bits 1 and 0 gate match B and match A requests
// - enable bit 6 reads 1, bits 3 and 2 read 0, none writable
// - status holds direction, underflow, overflow, match B, match A; fixed bits
// - software writes only 0 to flags to clear; a 1 has no effect
// - direction bit reads 1 counting up, 0 counting down
// - overflow on max-to-zero wrap, underflow on zero-to-max wrap
// - match flag sets on compare equality (codes 0xxx) or on capture load
// - flag clears on 0 write after a read that saw 1; match A flag also by DMA
//
// Local design decision: the plain strobed port.
`include "tmcc_cfg.svh"
`default_nettype none
module tmcc_top (
  input  wire logic [`TMCC_ADDR_W-1:0] I_ADDR,
  input  wire logic [`TMCC_DATA_W-1:0] I_WDATA,
  input  wire logic                    I_WR,
  input  wire logic                    I_RD,
  input  wire logic                    I_REF_CLK,
  input  wire logic                    I_SYS_RST,
  input  wire logic [`TMCC_CNT_W-1:0]  I_COUNTER_VALUE,
  input  wire logic                    I_COUNT_UP,
  input  wire logic                    I_OVERFLOW,
  input  wire logic                    I_UNDERFLOW,
  input  wire logic                    I_MATCH_A,
  input  wire logic                    I_MATCH_B,
  input  wire logic                    I_CH0_EVENT_A,
  input  wire logic                    I_CH0_EVENT_C,
  input  wire logic                    I_PIN_A,
  input  wire logic                    I_PIN_B,
  input  wire logic                    I_DMA_ACK_A,
  output logic [`TMCC_DATA_W-1:0]      O_RDATA,
  output logic                         O_PIN_A,
  output logic                         O_PIN_A_OE,
  output logic                         O_PIN_B,
  output logic                         O_PIN_B_OE,
  output logic                         O_CAPTURE_A,
  output logic                         O_CAPTURE_B,
  output logic [`TMCC_CNT_W-1:0]       O_CAPTURE_VALUE,
  output logic                         O_ADC_START,
  output logic                         O_MATCH_A_IRQ,
  output logic                         O_MATCH_B_IRQ,
  output logic                         O_OVERFLOW_IRQ,
  output logic                         O_UNDERFLOW_IRQ,
  output logic                         O_IRQ
);
  import tmcc_pkg::*;

  localparam int NFLAG = 4;
  localparam int FPOS [NFLAG] = '{`TMCC_BIT_MATCH_A, `TMCC_BIT_MATCH_B,
                                  `TMCC_BIT_OVERFLOW, `TMCC_BIT_UNDERFLOW};

  logic [`TMCC_DATA_W-1:0] pin_io_mode_q;
  logic [`TMCC_DATA_W-1:0] irq_enable_q;
  logic [`TMCC_DATA_W-1:0] irq_enable_d;
  logic [`TMCC_DATA_W-1:0] event_log_q;
  logic [`TMCC_DATA_W-1:0] event_log_d;
  logic [`TMCC_DATA_W-1:0] event_mask_q;
  logic [`TMCC_DATA_W-1:0] status_rd;
  logic [`TMCC_DATA_W-1:0] rdata_d;
  logic                    mode_load_q;
  logic                    count_direction_bit_q;
  logic                    wr_mode;
  logic                    wr_en;
  logic                    wr_st;
  logic                    rd_st;
  logic                    wr_mask;
  logic                    rd_log;
  logic [1:0]              cap;
  logic [1:0]              cc_set;
  tmcc_pin_out_type        pin_out [2];
  tmcc_events_type         ev_set;
  tmcc_events_type         flag_d;
  tmcc_events_type         flag_q;

  assign wr_mode = I_WR && (I_ADDR == `TMCC_ADDR_IO_MODE);
  assign wr_en   = I_WR && (I_ADDR == `TMCC_ADDR_IRQ_EN);
  assign wr_st   = I_WR && (I_ADDR == `TMCC_ADDR_STATUS);
  assign rd_st   = I_RD && (I_ADDR == `TMCC_ADDR_STATUS);
  assign wr_mask = I_WR && (I_ADDR == `TMCC_ADDR_EVENT_MASK);
  assign rd_log  = I_RD && (I_ADDR == `TMCC_ADDR_EVENT_LOG);

  // mode register and deferred initial-level load
  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      pin_io_mode_q <= `TMCC_IO_MODE_RST;
      mode_load_q   <= 1'b0;
    end else begin
      mode_load_q <= wr_mode;
      if (wr_mode) begin
        pin_io_mode_q <= I_WDATA;
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_chan
      tmcc_pin_chan u_chan (
        .i_clk       (I_REF_CLK),
        .i_rst       (I_SYS_RST),
        .i_mode      (pin_io_mode_q[4*gi +: 4]),
        .i_mode_load (mode_load_q),
        .i_match     ((gi == 0) ? I_MATCH_A : I_MATCH_B),
        .i_pin       ((gi == 0) ? I_PIN_A : I_PIN_B),
        .i_ch0_event ((gi == 0) ? I_CH0_EVENT_A : I_CH0_EVENT_C),
        .o_pin       (pin_out[gi]),
        .o_capture   (cap[gi]),
        .o_flag_set  (cc_set[gi])
      );
    end
  endgenerate

  assign ev_set = '{underflow: I_UNDERFLOW, overflow: I_OVERFLOW,
                    match_b: cc_set[1], match_a: cc_set[0]};

  generate
    for (gi = 0; gi < NFLAG; gi++) begin : g_flag
      tmcc_flag_bit u_flag (
        .i_clk     (I_REF_CLK),
        .i_rst     (I_SYS_RST),
        .i_set     (ev_set[gi]),
        .i_rd      (rd_st),
        .i_wr      (wr_st),
        .i_wbit    (I_WDATA[FPOS[gi]]),
        .i_dma_clr ((gi == 0) ? I_DMA_ACK_A : 1'b0),
        .o_flag_d  (flag_d[gi]),
        .o_flag_q  (flag_q[gi])
      );
    end
  endgenerate

  assign irq_enable_d = wr_en ?
    ((I_WDATA & `TMCC_IRQ_EN_WMSK) | `TMCC_IRQ_EN_RST) : irq_enable_q;

  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      irq_enable_q <= `TMCC_IRQ_EN_RST;
    end else begin
      irq_enable_q <= irq_enable_d;
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      count_direction_bit_q <= 1'b1;
    end else begin
      count_direction_bit_q <= I_COUNT_UP;
    end
  end

  always_comb begin
    status_rd                      = `TMCC_STATUS_RST & 8'h40;
    status_rd[`TMCC_BIT_DIR]       = count_direction_bit_q;
    status_rd[`TMCC_BIT_UNDERFLOW] = flag_q.underflow;
    status_rd[`TMCC_BIT_OVERFLOW]  = flag_q.overflow;
    status_rd[`TMCC_BIT_MATCH_B]   = flag_q.match_b;
    status_rd[`TMCC_BIT_MATCH_A]   = flag_q.match_a;
  end

  always_comb begin
    unique case (I_ADDR)
      `TMCC_ADDR_IO_MODE:    rdata_d = pin_io_mode_q;
      `TMCC_ADDR_IRQ_EN:     rdata_d = irq_enable_q;
      `TMCC_ADDR_STATUS:     rdata_d = status_rd;
      `TMCC_ADDR_EVENT_LOG:  rdata_d = event_log_q;
      `TMCC_ADDR_EVENT_MASK: rdata_d = event_mask_q;
      default:               rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      O_RDATA <= 8'h00;
    end else begin
      O_RDATA <= I_RD ? rdata_d : 8'h00;
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      O_MATCH_A_IRQ   <= 1'b0;
      O_MATCH_B_IRQ   <= 1'b0;
      O_OVERFLOW_IRQ  <= 1'b0;
      O_UNDERFLOW_IRQ <= 1'b0;
    end else begin
      O_MATCH_A_IRQ   <= flag_d.match_a & irq_enable_d[`TMCC_BIT_MATCH_A];
      O_MATCH_B_IRQ   <= flag_d.match_b & irq_enable_d[`TMCC_BIT_MATCH_B];
      O_OVERFLOW_IRQ  <= flag_d.overflow & irq_enable_d[`TMCC_BIT_OVERFLOW];
      O_UNDERFLOW_IRQ <= flag_d.underflow & irq_enable_d[`TMCC_BIT_UNDERFLOW];
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      O_ADC_START <= 1'b0;
    end else begin
      O_ADC_START <= cc_set[0] & irq_enable_q[`TMCC_BIT_ADC_TRIG];
    end
  end

  // capture strobes and value
  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      O_CAPTURE_A     <= 1'b0;
      O_CAPTURE_B     <= 1'b0;
      O_CAPTURE_VALUE <= '0;
    end else begin
      O_CAPTURE_A <= cap[0];
      O_CAPTURE_B <= cap[1];
      if (|cap) begin
        O_CAPTURE_VALUE <= I_COUNTER_VALUE;
      end
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      O_PIN_A    <= 1'b0;
      O_PIN_A_OE <= 1'b0;
      O_PIN_B    <= 1'b0;
      O_PIN_B_OE <= 1'b0;
    end else begin
      O_PIN_A    <= pin_out[0].level;
      O_PIN_A_OE <= pin_out[0].oe;
      O_PIN_B    <= pin_out[1].level;
      O_PIN_B_OE <= pin_out[1].oe;
    end
  end

  // sticky event log, read clears, set wins
  always_comb begin
    event_log_d                     = rd_log ? 8'h00 : event_log_q;
    event_log_d[`TMCC_EV_MATCH_A]   = event_log_d[`TMCC_EV_MATCH_A] | ev_set.match_a;
    event_log_d[`TMCC_EV_MATCH_B]   = event_log_d[`TMCC_EV_MATCH_B] | ev_set.match_b;
    event_log_d[`TMCC_EV_OVERFLOW]  = event_log_d[`TMCC_EV_OVERFLOW] | ev_set.overflow;
    event_log_d[`TMCC_EV_UNDERFLOW] = event_log_d[`TMCC_EV_UNDERFLOW] | ev_set.underflow;
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      event_log_q  <= 8'h00;
      event_mask_q <= `TMCC_EV_MASK_RST;
      O_IRQ        <= 1'b0;
    end else begin
      event_log_q <= event_log_d;
      if (wr_mask) begin
        event_mask_q <= I_WDATA;
      end
      O_IRQ <= |(event_log_d & (wr_mask ? I_WDATA : event_mask_q));
    end
  end

  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (I_SYS_RST);

  a_mode_off_pin: assert property (
    pin_io_mode_q[3:0] == 4'h0 && $past(pin_io_mode_q[3:0]) == 4'h0 |=> !O_PIN_A_OE)
    else $error("pin A driven with zero mode");

  a_match_low: assert property (
    pin_io_mode_q[3:0] == 4'h5 && !mode_load_q && I_MATCH_A && !wr_mode
      |=> ##1 !O_PIN_A)
    else $error("pin A not low after match");

  a_init_high: assert property (
    wr_mode && I_WDATA[3:0] == 4'h6 |=> ##2 O_PIN_A && O_PIN_A_OE)
    else $error("pin A initial level not 1");

  a_rise_capture: assert property (
    pin_io_mode_q[3:0] == 4'h8 && !I_PIN_A ##1
      pin_io_mode_q[3:0] == 4'h8 && I_PIN_A |=> O_CAPTURE_A)
    else $error("rising edge missed");

  a_fall_capture: assert property (
    pin_io_mode_q[7:4] == 4'h9 && I_PIN_B ##1
      pin_io_mode_q[7:4] == 4'h9 && !I_PIN_B |=> O_CAPTURE_B)
    else $error("falling edge missed");

  a_ch0_capture: assert property (
    pin_io_mode_q[7:6] == 2'b11 && I_CH0_EVENT_C |=> O_CAPTURE_B)
    else $error("channel 0 event not captured");

  a_adc_gate: assert property (
    O_ADC_START |-> $past(irq_enable_q[`TMCC_BIT_ADC_TRIG]) && $past(cc_set[0]))
    else $error("converter start without enable");

  a_udf_gate: assert property (
    O_UNDERFLOW_IRQ == (flag_q.underflow & irq_enable_q[`TMCC_BIT_UNDERFLOW]))
    else $error("underflow request mismatch");

  a_ovf_gate: assert property (
    O_OVERFLOW_IRQ == (flag_q.overflow & irq_enable_q[`TMCC_BIT_OVERFLOW]))
    else $error("overflow request mismatch");

  a_match_gate: assert property (
    O_MATCH_B_IRQ == (flag_q.match_b & irq_enable_q[`TMCC_BIT_MATCH_B]))
    else $error("match B request mismatch");

  a_enable_fixed: assert property (
    irq_enable_q[6] && irq_enable_q[3:2] == 2'b00)
    else $error("fixed enable bits changed");

  a_status_fixed: assert property (
    rd_st |=> O_RDATA[6] && O_RDATA[3:2] == 2'b00)
    else $error("fixed status bits wrong");

  a_one_write_keeps: assert property (
    flag_q.overflow && wr_st && I_WDATA[`TMCC_BIT_OVERFLOW] |=> flag_q.overflow)
    else $error("one write cleared flag");

  a_dir_follow: assert property (
    rd_st ##1 1'b1 |-> O_RDATA[`TMCC_BIT_DIR] == $past(I_COUNT_UP, 2))
    else $error("direction bit wrong");

  a_ovf_sets: assert property (
    I_OVERFLOW |=> flag_q.overflow && event_log_q[`TMCC_EV_OVERFLOW])
    else $error("overflow not flagged");

  a_match_sets: assert property (
    I_MATCH_A && !pin_io_mode_q[3] |=> flag_q.match_a)
    else $error("compare match not flagged");

  a_read_then_clear: assert property (
    rd_st && flag_q.match_b ##1 !wr_st ##1
      wr_st && !I_WDATA[`TMCC_BIT_MATCH_B] && !cc_set[1] |=> !flag_q.match_b)
    else $error("flag not cleared after read");

  a_irq_a_track: assert property (
    O_MATCH_A_IRQ == (flag_q.match_a & irq_enable_q[`TMCC_BIT_MATCH_A]))
    else $error("match A request mismatch");

  c_toggle: cover property (pin_io_mode_q[3:0] == 4'h3 && I_MATCH_A ##2 O_PIN_A_OE);
  c_capture_both: cover property (pin_io_mode_q[7:5] == 3'b101 ##1 O_CAPTURE_B);
  c_clear_seq: cover property (rd_st && flag_q.overflow ##2
    wr_st && !I_WDATA[`TMCC_BIT_OVERFLOW] ##1 !flag_q.overflow);
  c_irq: cover property (O_IRQ);
endmodule : tmcc_top
`default_nettype wire

// ===== tmcc_cfg.svh
`ifndef TMCC_CFG_SVH
`define TMCC_CFG_SVH

// register addresses
`define TMCC_ADDR_IO_MODE    32'hFFFF8282
`define TMCC_ADDR_IRQ_EN     32'hFFFF8284
`define TMCC_ADDR_STATUS     32'hFFFF8285
`define TMCC_ADDR_EVENT_LOG  32'hFFFF8290
`define TMCC_ADDR_EVENT_MASK 32'hFFFF8291

// widths
`define TMCC_ADDR_W 32
`define TMCC_DATA_W 8
`define TMCC_CNT_W  16

// enable, status and mode field bit positions
`define TMCC_BIT_ADC_TRIG   7
`define TMCC_BIT_DIR        7
`define TMCC_BIT_FIXED_ONE  6
`define TMCC_BIT_UNDERFLOW  5
`define TMCC_BIT_OVERFLOW   4
`define TMCC_BIT_MATCH_B    1
`define TMCC_BIT_MATCH_A    0
`define TMCC_MODE_A_LSB     0
`define TMCC_MODE_B_LSB     4

// event log bit positions
`define TMCC_EV_MATCH_A   0
`define TMCC_EV_MATCH_B   1
`define TMCC_EV_OVERFLOW  2
`define TMCC_EV_UNDERFLOW 3

// reset values and enable write mask
`define TMCC_IO_MODE_RST 8'h00
`define TMCC_IRQ_EN_RST  8'h40
`define TMCC_STATUS_RST  8'hC0
`define TMCC_IRQ_EN_WMSK 8'hB3
`define TMCC_EV_MASK_RST 8'h00

`endif

// ===== tmcc_pkg.sv
`default_nettype none
package tmcc_pkg;
  typedef enum logic [1:0] {
    MC_OUT_OFF,
    MC_OUT_CMP,
    MC_CAP_PIN,
    MC_CAP_CH0
  } tmcc_mode_class_type;

  typedef struct packed {
    logic level;
    logic oe;
  } tmcc_pin_out_type;

  typedef struct packed {
    logic underflow;
    logic overflow;
    logic match_b;
    logic match_a;
  } tmcc_events_type;
endpackage : tmcc_pkg
`default_nettype wire

// ===== tmcc_flag_bit.sv
`default_nettype none
module tmcc_flag_bit (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_set,
  input  wire logic i_rd,
  input  wire logic i_wr,
  input  wire logic i_wbit,
  input  wire logic i_dma_clr,
  output logic      o_flag_d,
  output logic      o_flag_q
);
  import tmcc_pkg::*;

  logic armed_q;
  logic armed_d;
  logic clear_req;

  always_comb begin
    clear_req = (i_wr & ~i_wbit & armed_q) | i_dma_clr;
    o_flag_d  = o_flag_q;
    armed_d   = armed_q;
    if (i_rd && o_flag_q) begin
      armed_d = 1'b1;
    end
    if (clear_req) begin
      o_flag_d = 1'b0;
      armed_d  = 1'b0;
    end
    // set wins over a clear
    if (i_set) begin
      o_flag_d = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_flag_q <= 1'b0;
      armed_q  <= 1'b0;
    end else begin
      o_flag_q <= o_flag_d;
      armed_q  <= armed_d;
    end
  end
endmodule : tmcc_flag_bit
`default_nettype wire

// ===== tmcc_pin_chan.sv
`default_nettype none
module tmcc_pin_chan (
  input  wire logic                 i_clk,
  input  wire logic                 i_rst,
  input  wire logic [3:0]           i_mode,
  input  wire logic                 i_mode_load,
  input  wire logic                 i_match,
  input  wire logic                 i_pin,
  input  wire logic                 i_ch0_event,
  output tmcc_pkg::tmcc_pin_out_type o_pin,
  output logic                      o_capture,
  output logic                      o_flag_set
);
  import tmcc_pkg::*;

  tmcc_mode_class_type cls;
  logic                pin_prev_q;
  logic                pin_hit;

  always_comb begin
    unique case (i_mode[3:2])
      2'b00, 2'b01: cls = (i_mode[1:0] == 2'h0) ? MC_OUT_OFF : MC_OUT_CMP;
      2'b10:        cls = MC_CAP_PIN;
      2'b11:        cls = MC_CAP_CH0;
    endcase
  end

  always_comb begin
    unique case (i_mode[1:0])
      2'b00:        pin_hit = i_pin & ~pin_prev_q;
      2'b01:        pin_hit = ~i_pin & pin_prev_q;
      2'b10, 2'b11: pin_hit = i_pin ^ pin_prev_q;
    endcase
  end

  assign o_capture  = (cls == MC_CAP_PIN) ? pin_hit :
                      (cls == MC_CAP_CH0) ? i_ch0_event : 1'b0;
  assign o_flag_set = (~i_mode[3] & i_match) | o_capture;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pin_prev_q <= 1'b0;
    end else begin
      pin_prev_q <= i_pin;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_pin <= '0;
    end else begin
      o_pin.oe <= (cls == MC_OUT_CMP);
      if (i_mode_load) begin
        o_pin.level <= i_mode[2];
      end else if (cls == MC_OUT_CMP && i_match) begin
        unique case (i_mode[1:0])
          2'b01: o_pin.level <= 1'b0;
          2'b10: o_pin.level <= 1'b1;
          2'b11: o_pin.level <= ~o_pin.level;
          default: o_pin.level <= o_pin.level;
        endcase
      end
    end
  end
endmodule : tmcc_pin_chan
`default_nettype wire

// ===== tmcc_pin_model.sv
`default_nettype none
module tmcc_pin_model (
  input  wire logic i_drv_a,
  input  wire logic i_oe_a,
  input  wire logic i_drv_b,
  input  wire logic i_oe_b,
  input  wire logic i_ext_a,
  input  wire logic i_ext_b,
  output logic      o_wire_a,
  output logic      o_wire_b
);
  timeunit 1ns;
  timeprecision 1ps;
  // pin level: channel drives while enabled, else the outside circuit
  assign o_wire_a = i_oe_a ? i_drv_a : i_ext_a;
  assign o_wire_b = i_oe_b ? i_drv_b : i_ext_b;
endmodule : tmcc_pin_model
`default_nettype wire

// ===== tmcc_top_tb.sv
`include "tmcc_cfg.svh"
`default_nettype none
module tmcc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] addr;
  logic [7:0]  wdata;
  logic [7:0]  d;
  logic        wr, rd, clk, rst, up, ext_a, ext_b, pin_a, pin_b;
  logic [15:0] cnt;
  logic [6:0]  ev;
  logic [7:0]  o_rdata;
  logic        o_pa, o_pa_oe, o_pb, o_pb_oe, cap_a, cap_b, adc, irq;
  logic [15:0] cap_v;
  logic [3:0]  irqs;
  int          fails, compares, na, nb, nadc;

  tmcc_top i_dut (.I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .I_REF_CLK(clk),
    .I_SYS_RST(rst), .I_COUNTER_VALUE(cnt), .I_COUNT_UP(up), .I_OVERFLOW(ev[2]),
    .I_UNDERFLOW(ev[3]), .I_MATCH_A(ev[0]), .I_MATCH_B(ev[1]), .I_CH0_EVENT_A(ev[4]),
    .I_CH0_EVENT_C(ev[5]), .I_PIN_A(pin_a), .I_PIN_B(pin_b), .I_DMA_ACK_A(ev[6]),
    .O_RDATA(o_rdata), .O_PIN_A(o_pa), .O_PIN_A_OE(o_pa_oe), .O_PIN_B(o_pb),
    .O_PIN_B_OE(o_pb_oe), .O_CAPTURE_A(cap_a), .O_CAPTURE_B(cap_b), .O_CAPTURE_VALUE(cap_v),
    .O_ADC_START(adc), .O_MATCH_A_IRQ(irqs[0]), .O_MATCH_B_IRQ(irqs[1]),
    .O_OVERFLOW_IRQ(irqs[2]), .O_UNDERFLOW_IRQ(irqs[3]), .O_IRQ(irq));

  tmcc_pin_model i_pins (.i_drv_a(o_pa), .i_oe_a(o_pa_oe), .i_drv_b(o_pb), .i_oe_b(o_pb_oe),
    .i_ext_a(ext_a), .i_ext_b(ext_b), .o_wire_a(pin_a), .o_wire_b(pin_b));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wr_reg(input logic [31:0] a, input logic [7:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    #1;
  endtask : wr_reg

  task automatic rd_reg(input logic [31:0] a);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 d = o_rdata;
  endtask : rd_reg

  task automatic pulse(input logic [6:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 7'h00;
  endtask : pulse

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  // counts capture and converter pulses over four cycles, current one first
  task automatic caps;
    na = 0;
    nb = 0;
    nadc = 0;
    repeat (4) begin
      #1;
      na += int'(cap_a !== 1'b0);
      nb += int'(cap_b !== 1'b0);
      nadc += int'(adc !== 1'b0);
      @(posedge clk);
    end
    #1;
  endtask : caps

  task automatic t_reset;
    rd_reg(`TMCC_ADDR_IRQ_EN);
    check(16'(d), 16'h0040);
    rd_reg(`TMCC_ADDR_STATUS);
    check(16'(d), 16'h00C0);
    rd_reg(`TMCC_ADDR_IO_MODE);
    check(16'(d), 16'h0000);
    rd_reg(32'hFFFF8287);
    check(16'(d), 16'h0000);
    wr_reg(`TMCC_ADDR_IRQ_EN, 8'hFF);
    rd_reg(`TMCC_ADDR_IRQ_EN);
    check(16'(d), 16'h00F3);
    wr_reg(`TMCC_ADDR_IRQ_EN, 8'h00);
    rd_reg(`TMCC_ADDR_IRQ_EN);
    check(16'(d), 16'h0040);
  endtask : t_reset

  task automatic t_flags;
    int b;
    for (int i = 0; i < 4; i++) begin
      b = (i < 2) ? i : i + 2;
      pulse(7'h01 << i);
      cyc(1);
      check(16'(irqs[i]), 16'h0000);
      wr_reg(`TMCC_ADDR_IRQ_EN, 8'h01 << b);
      check(16'(irqs[i]), 16'h0001);
      wr_reg(`TMCC_ADDR_STATUS, 8'h00);
      rd_reg(`TMCC_ADDR_STATUS);
      check(16'(d), 16'(8'hC0 | (8'h01 << b)));
      wr_reg(`TMCC_ADDR_STATUS, 8'hFF);
      rd_reg(`TMCC_ADDR_STATUS);
      check(16'(d), 16'(8'hC0 | (8'h01 << b)));
      wr_reg(`TMCC_ADDR_STATUS, 8'h00);
      check(16'(irqs[i]), 16'h0000);
      rd_reg(`TMCC_ADDR_STATUS);
      check(16'(d), 16'h00C0);
      wr_reg(`TMCC_ADDR_IRQ_EN, 8'h00);
    end
  endtask : t_flags

  task automatic t_compare;
    logic [3:0] c;
    logic       en, lv;
    for (int i = 0; i < 8; i++) begin
      c = 4'(i);
      wr_reg(`TMCC_ADDR_IO_MODE, {c, c});
      cyc(3);
      en = (c != 4'h0) && (c != 4'h4);
      check(16'(o_pa_oe), 16'(en));
      check(16'(o_pb_oe), 16'(en));
      if (en) begin
        check(16'(o_pa), 16'(c[2]));
        pulse(7'h03);
        cyc(2);
        lv = (c[1:0] == 2'h1) ? 1'b0 : (c[1:0] == 2'h2) ? 1'b1 : ~c[2];
        check(16'(o_pa), 16'(lv));
        check(16'(o_pb), 16'(lv));
      end
    end
    wr_reg(`TMCC_ADDR_IO_MODE, 8'h00);
  endtask : t_compare

  task automatic t_capture;
    logic [3:0] c;
    logic       er, ef, eh;
    for (int i = 8; i < 16; i++) begin
      c = 4'(i);
      er = (c == 4'h8) || (c[3:1] == 3'h5);
      ef = (c == 4'h9) || (c[3:1] == 3'h5);
      eh = (c[3:2] == 2'h3);
      wr_reg(`TMCC_ADDR_IO_MODE, {c, c});
      @(posedge clk);
      cnt   <= 16'h1230 + 16'(i);
      ext_a <= 1'b1;
      ext_b <= 1'b1;
      caps();
      check(16'(na), 16'(er));
      check(16'(nb), 16'(er));
      if (er) check(cap_v, 16'h1230 + 16'(i));
      @(posedge clk);
      ext_a <= 1'b0;
      ext_b <= 1'b0;
      caps();
      check(16'(na), 16'(ef));
      check(16'(nb), 16'(ef));
      pulse(7'h10);
      caps();
      check(16'(na), 16'(eh));
      check(16'(nb), 16'h0000);
      pulse(7'h20);
      caps();
      check(16'(na), 16'h0000);
      check(16'(nb), 16'(eh));
    end
    wr_reg(`TMCC_ADDR_IO_MODE, 8'h00);
  endtask : t_capture

  task automatic t_adc_dma;
    wr_reg(`TMCC_ADDR_IRQ_EN, 8'h80);
    pulse(7'h01);
    caps();
    check(16'(nadc), 16'h0001);
    wr_reg(`TMCC_ADDR_IRQ_EN, 8'h00);
    pulse(7'h01);
    caps();
    check(16'(nadc), 16'h0000);
    rd_reg(`TMCC_ADDR_STATUS);
    check(16'(d & 8'h01), 16'h0001);
    pulse(7'h40);
    rd_reg(`TMCC_ADDR_STATUS);
    check(16'(d & 8'h01), 16'h0000);
  endtask : t_adc_dma

  task automatic t_log_dir;
    rd_reg(`TMCC_ADDR_EVENT_LOG);
    wr_reg(`TMCC_ADDR_EVENT_MASK, 8'h01);
    pulse(7'h01);
    cyc(2);
    check(16'(irq), 16'h0001);
    rd_reg(`TMCC_ADDR_EVENT_LOG);
    check(16'(d), 16'h0001);
    cyc(1);
    check(16'(irq), 16'h0000);
    @(posedge clk);
    up <= 1'b0;
    cyc(2);
    rd_reg(`TMCC_ADDR_STATUS);
    check(16'(d[7]), 16'h0000);
    @(posedge clk);
    up <= 1'b1;
    cyc(2);
    rd_reg(`TMCC_ADDR_STATUS);
    check(16'(d & 8'hCC), 16'h00C0);
  endtask : t_log_dir

  task automatic finish_test;
    if (fails == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test

  initial begin
    fails = 0;
    compares = 0;
    addr = 32'h00000000;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    rst = 1'b1;
    up = 1'b1;
    cnt = 16'h0000;
    ev = 7'h00;
    ext_a = 1'b0;
    ext_b = 1'b0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_flags();
    t_compare();
    t_capture();
    t_adc_dma();
    t_log_dir();
    finish_test();
  end
endmodule : tmcc_top_tb
`default_nettype wire
